// ===== sas_top.sv
// sas_top.sv: smoke alarm sequencer with AHB-Lite register slave
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module sas_top #(
   parameter int TICK_CYC = sas_pkg::TICK_CYC,
   parameter int EMITTER_DRIVE_CYC = sas_pkg::EMITTER_DRIVE_STEP_CYC
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        test_btn,
   input  wire logic        io_in,
   input  wire logic        lowbat_in,
   input  wire logic [4:0]  photo_code,
   output logic             io_out,
   output logic             io_oe,
   output logic             io_dump_en,
   output logic             boost_en,
   output logic             boost_high,
   output logic             high_gain,
   output logic             emitter_cap_charge,
   output logic             emitter_drive,
   output logic             horn_drive,
   output logic             alarm_lamp_out,
   output logic             memory_lamp_out
);
   localparam int PW = 20;
   // registers
   logic [31:0] ctrl_q, lim_q, rdata_q;
   logic [7:0]  addr_q;
   logic        wr_q;
   // timebase
   logic [16:0] pre_q;
   logic [9:0]  ms_q;
   logic [5:0]  s43_q;
   logic [2:0]  p8_q;
   // sequencer state
   sas_pkg::sas_st_t  st_q, st_d;
   sas_pkg::sas_job_t job_q;
   logic [3:0]  jms_q;
   logic [PW-1:0] pw_q;
   logic        pend_ch_q, pend_bt_q, loaded_q;
   logic [13:0] samp_q;
   logic [1:0]  cons_q, nos_q, cf_q;
   logic        btn_q, ptt_q, post_q, ptt_al_q, skip_q, memclr_q;
   logic        hush_q, lowbat_q, lbh_q, mem_q;
   logic [9:0]  hush_t_q, hold_q;
   logic [14:0] lbh_t_q;
   logic [16:0] mem_t_q;
   logic [20:0] age_t_q;
   logic [8:0]  age_q;
   logic [8:0]  iof_q;
   logic [10:0] dump_q;

   // bus decode
   wire a_ph   = hsel & htrans[1] & hready;
   wire [7:0] a_sel = haddr[7:0];
   wire       do_wr = wr_q;
   wire [31:0] stat = {7'h00, age_q, 6'h00, ptt_q, age_q >= 9'(sas_pkg::EOL_AGES),
                       cf_q, lbh_q, lowbat_q, mem_q, hush_q, st_q};
   wire [31:0] rd_mux = (a_sel == sas_pkg::A_CTRL) ? ctrl_q :
                        (a_sel == sas_pkg::A_LIM)  ? lim_q  :
                        (a_sel == sas_pkg::A_STAT) ? stat   : 32'h0000_0000;
   wire hcan = ctrl_q[sas_pkg::C_HCAN];
   wire lbs  = ctrl_q[sas_pkg::C_LBS];
   wire eol  = ctrl_q[sas_pkg::C_EOL];
   wire [1:0] it = ctrl_q[sas_pkg::C_IT +: 2];

   // zero wait state slave; read data set up in the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_q  <= 8'h00;
         wr_q    <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         addr_q  <= a_sel;
         wr_q    <= a_ph & hwrite & (hsize == 3'h2);
         rdata_q <= (a_ph & !hwrite) ? rd_mux : rdata_q;
      end
   end

   // software writes steer options, width and the four limits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= sas_pkg::CTRL_RST;
         lim_q  <= sas_pkg::LIM_RST;
      end
      else
      begin
         if (do_wr && addr_q == sas_pkg::A_CTRL)
            ctrl_q <= {27'h0000000, hwdata[4:0]};
         if (do_wr && addr_q == sas_pkg::A_LIM)
            lim_q <= hwdata & 32'h1F1F_1F1F;
      end
   end

   // chained free counter: ms, second in 43 s phase, 43 s period in 344 s
   wire tick    = pre_q == 17'(TICK_CYC - 1);
   wire sec_end = tick & (ms_q == 10'(sas_pkg::MS_PER_S - 1));
   wire ph_end  = sec_end & (s43_q == 6'(sas_pkg::PHASE_S - 1));
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pre_q <= 17'h00000;
         ms_q  <= 10'h000;
         s43_q <= 6'h00;
         p8_q  <= 3'h0;
      end
      else
      begin
         pre_q <= tick ? 17'h00000 : pre_q + 17'h00001;
         ms_q  <= sec_end ? 10'h000 : (tick ? ms_q + 10'h001 : ms_q);
         s43_q <= ph_end ? 6'h00 : (sec_end ? s43_q + 6'h01 : s43_q);
         p8_q  <= ph_end ? p8_q + 3'h1 : p8_q;
      end
   end

   // phase markers for chirps and flashes
   wire ph0      = tick & (ms_q == 10'h000);
   wire in10     = ms_q < 10'(sas_pkg::CHIRP_MS);
   wire [9:0] m1 = ms_q - 10'(sas_pkg::TRIPLE_MS);
   wire [9:0] m2 = ms_q - 10'(2 * sas_pkg::TRIPLE_MS);
   wire tri_ms   = in10 | (m1 < 10'(sas_pkg::CHIRP_MS)) | (m2 < 10'(sas_pkg::CHIRP_MS));
   wire [9:0] g1 = ms_q - 10'(sas_pkg::MEMSP_MS - sas_pkg::MS_PER_S);
   wire [9:0] g2 = ms_q - 10'(2 * sas_pkg::MEMSP_MS - 2 * sas_pkg::MS_PER_S);
   wire [9:0] l1 = ms_q - 10'(sas_pkg::LAMP_MS);
   wire [9:0] q4 = 10'(ms_q % 10'(sas_pkg::FAST_MS));

   // button edges and limit selection
   wire press   = test_btn & !btn_q;
   wire release_e = !test_btn & btn_q;
   wire testsel = ptt_q | (job_q == sas_pkg::J_CHAMB);
   wire [4:0] lim_sel = testsel ? lim_q[sas_pkg::L_CT +: 5] :
                        (st_q == sas_pkg::ST_LOCAL) ? lim_q[sas_pkg::L_HYS +: 5] :
                        hush_q ? lim_q[sas_pkg::L_HUSH +: 5] : lim_q[sas_pkg::L_NORM +: 5];

   // detection window job engine
   wire idle    = job_q == sas_pkg::J_IDLE;
   wire optical = (job_q == sas_pkg::J_SMOKE) | (job_q == sas_pkg::J_CHAMB);
   wire w_end   = !idle & tick & (jms_q == 4'(sas_pkg::WIN_MS - 1));
   wire p_go    = optical & tick & (jms_q == 4'(sas_pkg::PULSE_AT_MS));
   wire eval    = pw_q == PW'(1);
   wire above   = photo_code > lim_sel;
   wire s_eval  = eval & (job_q == sas_pkg::J_SMOKE);
   wire smk     = s_eval & above;
   wire clr     = s_eval & !above;
   wire [PW-1:0] emitter_drive_w = PW'((int'(it) + 1) * EMITTER_DRIVE_CYC);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         job_q    <= sas_pkg::J_IDLE;
         jms_q    <= 4'h0;
         pw_q     <= '0;
         loaded_q <= 1'b0;
      end
      else
      begin
         jms_q <= idle ? 4'h0 : (tick ? jms_q + 4'h1 : jms_q);
         pw_q  <= p_go ? emitter_drive_w : ((pw_q != '0) ? pw_q - PW'(1) : pw_q);
         if (idle && pend_bt_q)
         begin
            job_q    <= sas_pkg::J_BATT;
            loaded_q <= p8_q == 3'h0;
         end
         else if (idle && pend_ch_q)
            job_q <= sas_pkg::J_CHAMB;
         else if (idle && samp_q == 14'h0000)
            job_q <= sas_pkg::J_SMOKE;
         else if (w_end)
            job_q <= sas_pkg::J_IDLE;
      end
   end

   // supervisory requests wait while a window is busy
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_bt_q <= 1'b0;
         pend_ch_q <= 1'b0;
         lowbat_q  <= 1'b0;
         cf_q      <= 2'h0;
      end
      else
      begin
         if (ph_end && !p8_q[0])
            pend_bt_q <= 1'b1;
         else if (idle)
            pend_bt_q <= 1'b0;
         if (sec_end && s43_q == 6'(sas_pkg::CHB_PH_S - 1))
            pend_ch_q <= 1'b1;
         else if (idle && !pend_bt_q)
            pend_ch_q <= 1'b0;
         if (w_end && job_q == sas_pkg::J_BATT)
            lowbat_q <= lowbat_in;
         if (eval && job_q == sas_pkg::J_CHAMB)
            cf_q <= above ? 2'h0 : ((cf_q == 2'h2) ? cf_q : cf_q + 2'h1);
      end
   end

   // sample interval and consecutive counts
   wire [13:0] nxt_int = (ptt_q | post_q) ? 14'(sas_pkg::FAST_MS) :
                         (smk | st_q == sas_pkg::ST_LOCAL) ? 14'(sas_pkg::VERIFY_MS) :
                         14'(sas_pkg::SAMPLE_MS);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         samp_q <= 14'(sas_pkg::SAMPLE_MS);
         cons_q <= 2'h0;
         nos_q  <= 2'h0;
      end
      else
      begin
         if (press)
            samp_q <= 14'(sas_pkg::FAST_MS);
         else if (s_eval)
            samp_q <= nxt_int;
         else if (tick && samp_q != 14'h0000)
            samp_q <= samp_q - 14'h0001;
         if (s_eval)
            cons_q <= above ? ((cons_q == 2'h3) ? cons_q : cons_q + 2'h1) : 2'h0;
         if (release_e)
            nos_q <= 2'h0;
         else if (s_eval)
            nos_q <= above ? 2'h0 : nos_q + 2'h1;
      end
   end

   // alarm state: local, remote, standby
   wire io_ok   = iof_q >= 9'(sas_pkg::IOFILT_MS);
   wire third   = smk & (cons_q == 2'h2);
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         sas_pkg::ST_STBY:
            if (third)
               st_d = sas_pkg::ST_LOCAL;
            else if (io_ok)
               st_d = sas_pkg::ST_REMOTE;
         sas_pkg::ST_REMOTE:
            if (third)
               st_d = sas_pkg::ST_LOCAL;
            else if (!io_in)
               st_d = sas_pkg::ST_STBY;
         sas_pkg::ST_LOCAL:
            if ((press && !ptt_al_q) || clr)
               st_d = sas_pkg::ST_STBY;
      endcase
   end
   wire lx = (st_q == sas_pkg::ST_LOCAL) & (st_d != sas_pkg::ST_LOCAL);

   // interconnect filter; own line ignored in alarm and while dumping
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q   <= sas_pkg::ST_STBY;
         iof_q  <= 9'h000;
         dump_q <= 11'h000;
      end
      else
      begin
         st_q <= st_d;
         if (st_q == sas_pkg::ST_LOCAL || dump_q != 11'h000 || !io_in)
            iof_q <= 9'h000;
         else if (tick && !io_ok)
            iof_q <= iof_q + 9'h001;
         if (lx)
            dump_q <= 11'(sas_pkg::DUMP_MS);
         else if (st_q == sas_pkg::ST_LOCAL)
            dump_q <= 11'h000;                                            // no sink while driving
         else if (tick && dump_q != 11'h000)
            dump_q <= dump_q - 11'h001;
      end
   end

   // test button, hush, battery silence, memory
   wire hold_ok = hold_q >= 10'(sas_pkg::HOLD_MS);
   wire hcancel = hcan & hush_q & ((s_eval & above) | io_ok | press);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         btn_q <= 1'b0; ptt_q <= 1'b0; post_q <= 1'b0; ptt_al_q <= 1'b0;
         skip_q <= 1'b0; memclr_q <= 1'b0; hush_q <= 1'b0; hush_t_q <= 10'h000;
         hold_q <= 10'h000; lbh_q <= 1'b0; lbh_t_q <= 15'h0000; mem_q <= 1'b0;
         mem_t_q <= 17'h00000;
      end
      else
      begin
         btn_q <= test_btn;
         ptt_q <= test_btn;
         if (st_d == sas_pkg::ST_LOCAL && st_q != sas_pkg::ST_LOCAL)
            ptt_al_q <= ptt_q;
         if (release_e)
            post_q <= 1'b1;
         else if (clr && nos_q == 2'h2)
            post_q <= 1'b0;
         hold_q <= !test_btn ? 10'h000 : ((tick && !hold_ok) ? hold_q + 10'h001 : hold_q);
         if (press)
            skip_q <= hcan & hush_q;
         else if (release_e)
            skip_q <= 1'b0;
         if (hcancel)
            hush_q <= 1'b0;
         else if (release_e && !skip_q && !hush_q)
         begin
            hush_q   <= 1'b1;
            hush_t_q <= 10'h000;
         end
         else if (sec_end && hush_q)
         begin
            hush_t_q <= hush_t_q + 10'h001;
            hush_q   <= hush_t_q != 10'(sas_pkg::HUSH_S - 1);
         end
         if (release_e && lbs && lowbat_q && hold_ok)
         begin
            lbh_q   <= 1'b1;
            lbh_t_q <= 15'h0000;
         end
         else if (sec_end && lbh_q)
         begin
            lbh_t_q <= lbh_t_q + 15'h0001;
            lbh_q   <= lbh_t_q != 15'(sas_pkg::LBH_S - 1);
         end
         if (press)
            memclr_q <= mem_q;
         if (lx && !ptt_al_q)
         begin
            mem_q   <= 1'b1;
            mem_t_q <= 17'h00000;
         end
         else if (release_e && memclr_q)
            mem_q <= 1'b0;
         else if (sec_end && mem_q && mem_t_q != 17'(sas_pkg::MEM_S))
            mem_t_q <= mem_t_q + 17'h00001;
      end
   end

   // age count every 14 days of operation
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         age_t_q <= 21'h000000;
         age_q   <= 9'h000;
      end
      else if (sec_end && eol)
      begin
         age_t_q <= (age_t_q == 21'(sas_pkg::AGE_S - 1)) ? 21'h000000 : age_t_q + 21'h000001;
         if (age_t_q == 21'(sas_pkg::AGE_S - 1) && age_q != 9'h1FF)
            age_q <= age_q + 9'h001;
      end
   end

   // indications
   wire local_a  = st_q == sas_pkg::ST_LOCAL;
   wire remote_a = st_q == sas_pkg::ST_REMOTE;
   wire eol_due  = eol & (age_q >= 9'(sas_pkg::EOL_AGES));
   wire chirp1   = (s43_q == 6'h00) & in10 & ((lowbat_q & !lbh_q) | cf_q == 2'h1);
   wire chirp3   = (s43_q == 6'(sas_pkg::TRIPLE_PH_S)) & tri_ms &
                   ((cf_q == 2'h2) | eol_due);
   wire memchirp = test_btn & mem_q & (q4 < 10'(sas_pkg::CHIRP_MS));
   wire horn_d   = local_a | remote_a | chirp1 | chirp3 | memchirp;
   wire al_flash = local_a & (in10 | (l1 < 10'(sas_pkg::CHIRP_MS)));
   wire hu_flash = hush_q & !local_a & !remote_a & in10 &
                   (10'(hush_t_q % 10'(sas_pkg::FLASH_S)) == 10'h000);
   wire lb_lamp  = test_btn & lbs & lowbat_q;
   wire bt_load  = (job_q == sas_pkg::J_BATT) & loaded_q;
   wire lamp_d   = al_flash | hu_flash | lb_lamp | bt_load;
   wire memvis   = mem_q & !lowbat_q & (mem_t_q != 17'(sas_pkg::MEM_S));
   wire gm       = ((s43_q == 6'(sas_pkg::MEM_PH_S)) & in10) |
                   ((s43_q == 6'(sas_pkg::MEM_PH_S + 1)) & (g1 < 10'(sas_pkg::CHIRP_MS))) |
                   ((s43_q == 6'(sas_pkg::MEM_PH_S + 2)) & (g2 < 10'(sas_pkg::CHIRP_MS)));
   wire gl_d     = memvis & gm;

   // every pin output but the constant hreadyout and hresp leaves from a flip-flop
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         io_out <= 1'b0; io_oe <= 1'b0; io_dump_en <= 1'b0; boost_en <= 1'b0;
         boost_high <= 1'b0; high_gain <= 1'b0; emitter_cap_charge <= 1'b0;
         emitter_drive <= 1'b0; horn_drive <= 1'b0; alarm_lamp_out <= 1'b0;
         memory_lamp_out <= 1'b0;
      end
      else
      begin
         io_out     <= local_a;
         io_oe      <= local_a;
         io_dump_en <= dump_q != 11'h000;
         boost_en   <= !idle | local_a | remote_a;
         boost_high <= bt_load | local_a | remote_a;
         high_gain  <= testsel;
         emitter_cap_charge <= optical & (jms_q < 4'(sas_pkg::PULSE_AT_MS));
         emitter_drive   <= pw_q > PW'(1);
         horn_drive      <= horn_d;
         alarm_lamp_out  <= lamp_d;
         memory_lamp_out <= gl_d;
      end
   end

   assign hrdata    = rdata_q;
   assign hreadyout = !wr_q | wr_q;
   assign hresp     = 1'b0;
endmodule

// ===== sas_pkg.sv
// sas_pkg.sv: constants and types of the smoke alarm sequencer
package sas_pkg;
   localparam int CLK_MHZ     = 100;
   localparam int TICK_US     = 1000;
   localparam int TICK_CYC    = TICK_US * CLK_MHZ;
   localparam int EMITTER_DRIVE_STEP_US = 100;
   localparam int EMITTER_DRIVE_STEP_CYC = EMITTER_DRIVE_STEP_US * CLK_MHZ;
   // times in milliseconds
   localparam int MS_PER_S    = 1000;
   localparam int SAMPLE_MS   = 10000;
   localparam int VERIFY_MS   = 1000;
   localparam int FAST_MS     = 250;
   localparam int WIN_MS      = 10;
   localparam int PULSE_AT_MS = 2;
   localparam int CHIRP_MS    = 10;
   localparam int LAMP_MS     = 500;
   localparam int TRIPLE_MS   = 330;
   localparam int MEMSP_MS    = 1300;
   localparam int HOLD_MS     = 500;
   localparam int IOFILT_MS   = 336;
   localparam int DUMP_MS     = 1300;
   // times in seconds; EOL_AGES is a count of 14 day ages
   localparam int PHASE_S     = 43;
   localparam int CHB_PH_S    = 1;
   localparam int TRIPLE_PH_S = 20;
   localparam int MEM_PH_S    = 30;
   localparam int FLASH_S     = 10;
   localparam int HUSH_S      = 540;
   localparam int LBH_S       = 28800;
   localparam int MEM_S       = 86400;
   localparam int AGE_S       = 1209600;
   localparam int EOL_AGES    = 261;
   // register map
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_LIM  = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam int C_HCAN = 0;
   localparam int C_LBS  = 1;
   localparam int C_EOL  = 2;
   localparam int C_IT   = 3;
   localparam int L_NORM = 0;
   localparam int L_HYS  = 8;
   localparam int L_HUSH = 16;
   localparam int L_CT   = 24;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] LIM_RST  = 32'h0818_0C10;
   typedef enum logic [1:0] {ST_STBY, ST_LOCAL, ST_REMOTE} sas_st_t;
   typedef enum logic [1:0] {J_IDLE, J_SMOKE, J_CHAMB, J_BATT} sas_job_t;
endpackage

// ===== sas_checker.sv
// sas_checker.sv: port assertions for the smoke alarm sequencer
`timescale 1ns/10ps
module sas_checker #(
   parameter int TICK_CYC = 10,
   parameter int EMITTER_DRIVE_CYC = 2
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic test_btn,
   input wire logic io_out,
   input wire logic io_oe,
   input wire logic io_dump_en,
   input wire logic boost_en,
   input wire logic high_gain,
   input wire logic emitter_cap_charge,
   input wire logic emitter_drive,
   input wire logic horn_drive
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   int dump_c;
   int emit_c;
   // run lengths, too long for a repetition operator
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) dump_c <= 0;
      else dump_c <= io_dump_en ? dump_c + 1 : 0;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) emit_c <= 0;
      else emit_c <= emitter_drive ? emit_c + 1 : 0;
   // interconnect drive and discharge
   property p_io_pair; io_oe == io_out; endproperty
   a_io_pair: assert property (p_io_pair) else $error("io drive split");
   property p_dump_after; $fell(io_oe) |-> ##[0:2] io_dump_en; endproperty
   a_dump_after: assert property (p_dump_after) else $error("no discharge");
   property p_dump_excl; io_dump_en |-> !io_oe; endproperty
   a_dump_excl: assert property (p_dump_excl) else $error("discharge while driving");
   property p_dump_len; dump_c <= sas_pkg::DUMP_MS * TICK_CYC + TICK_CYC; endproperty
   a_dump_len: assert property (p_dump_len) else $error("discharge too long");
   // optical window
   property p_emit_boost; emitter_drive |-> boost_en; endproperty
   a_emit_boost: assert property (p_emit_boost) else $error("emitter without boost");
   property p_emit_len; emit_c <= 4 * EMITTER_DRIVE_CYC; endproperty
   a_emit_len: assert property (p_emit_len) else $error("emitter pulse too long");
   property p_cap_first; $fell(emitter_cap_charge) |-> ##[0:20] emitter_drive; endproperty
   a_cap_first: assert property (p_cap_first) else $error("no pulse after charge");
   // button and alarm outputs
   property p_gain_press; $rose(test_btn) |-> ##[1:3] high_gain; endproperty
   a_gain_press: assert property (p_gain_press) else $error("no high gain");
   property p_horn_alarm; $rose(io_oe) |-> ##[0:1] horn_drive; endproperty
   a_horn_alarm: assert property (p_horn_alarm) else $error("alarm without horn");
   c_local: cover property ($rose(io_oe));
   c_dump: cover property ($rose(io_dump_en));
   c_remote: cover property (horn_drive && !io_oe);
endmodule

bind sas_top sas_checker #(.TICK_CYC(TICK_CYC), .EMITTER_DRIVE_CYC(EMITTER_DRIVE_CYC)) sas_checker_inst (
   .hclk, .hresetn, .test_btn, .io_out, .io_oe, .io_dump_en, .boost_en, .high_gain,
   .emitter_cap_charge, .emitter_drive, .horn_drive);

// ===== sas_partner.sv
// sas_partner.sv: push-button and interconnect line model
`timescale 1ns/10ps
module sas_partner (
   input  wire logic hclk,
   input  wire logic press,
   input  wire logic remote,
   input  wire logic io_out,
   input  wire logic io_oe,
   output logic      test_btn,
   output logic      io_in
);
   initial test_btn = 1'b0;
   // button follows the press command one edge later
   always @(posedge hclk) test_btn <= press;
   // line has a pull-down, so released means low
   assign io_in = (io_oe & io_out) | remote;
endmodule

// ===== sas_tb_top.sv
// sas_tb_top.sv: self-checking bench for the smoke alarm sequencer
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module sas_tb_top;
   localparam int TK = 10;
   localparam int IR = 2;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0, vf = 0;
   logic        press = 0, remote = 0, lowbat_in = 0;
   logic [31:0] haddr = 0, hwdata = 0, obs = 0, ex, hrdata;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [4:0]  photo_code = 5'h09;
   logic        hreadyout, hresp, test_btn, io_in, io_out, io_oe, io_dump_en, boost_en;
   logic        boost_high, high_gain, emitter_cap_charge, emitter_drive, horn_drive;
   logic        alarm_lamp_out, memory_lamp_out;
   logic [31:0] exp_q[$];
   int          err_count = 0, n_checks = 0, t, n, lc;
   wire  [31:0] outs = {27'h0, io_out, io_oe, io_dump_en, horn_drive, high_gain};

   sas_top #(.TICK_CYC(TK), .EMITTER_DRIVE_CYC(IR)) sas_top_inst (.hready(hreadyout), .*);
   sas_partner sas_partner_inst (.hclk, .press, .remote, .io_out, .io_oe, .test_btn, .io_in);

   initial forever #5 hclk = ~hclk;

   task automatic wt;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask
   // single transfer; read data is judged by the monitor at the data-phase edge
   task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= sz;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= !w;
      wt();
      rd_ph <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(a, 1'b0, 3'h2, 32'h0);
   endtask
   // extra edge at the end so back-to-back notes never double-drive vf
   task automatic note(input logic [31:0] g, input logic [31:0] e);
      exp_q.push_back(e);
      obs <= g;
      vf <= 1'b1;
      @(posedge hclk);
      vf <= 1'b0;
      @(posedge hclk);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // monitor: oldest note against what appeared
   always @(posedge hclk)
   begin
      if (rd_ph || vf)
      begin
         ex = exp_q.pop_front();
         `CHK(rd_ph ? hrdata : obs, ex)
      end
   end

   initial
   begin
      repeat (80000) @(posedge hclk);
      err_count++;
      test_done();
   end

   initial
   begin
      void'($urandom(24610));
      photo_code <= 5'h09 + 5'($urandom % 7);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      note(outs, 32'h0);
      rd(32'(sas_pkg::A_CTRL), sas_pkg::CTRL_RST);
      rd(32'(sas_pkg::A_LIM), sas_pkg::LIM_RST);
      rd(32'h0000_000C, 32'h0);
      n = $urandom % 4;
      bus(32'(sas_pkg::A_CTRL), 1'b1, 3'h2, 32'(n) << 3);
      bus(32'(sas_pkg::A_LIM), 1'b1, 3'h0, 32'h0);
      bus(32'(sas_pkg::A_STAT), 1'b1, 3'h2, 32'hFFFF_FFFF);
      rd(32'(sas_pkg::A_CTRL), 32'(n) << 3);
      rd(32'(sas_pkg::A_LIM), sas_pkg::LIM_RST);
      rd(32'(sas_pkg::A_STAT), 32'h0);
      // chamber test at second 1 passes on the background code
      repeat (1100 * TK) @(posedge hclk);
      press <= 1'b1;
      photo_code <= 5'h1F;
      repeat (4) @(posedge hclk);
      note(outs, 32'h1);
      for (t = 0; t < 5000 && emitter_drive !== 1'b1; t++) @(posedge hclk);
      for (t = 0; t < 100 && emitter_drive === 1'b1; t++) @(posedge hclk);
      note(32'(t >= (n + 1) * IR - 1 && t <= (n + 1) * IR), 32'h1);
      for (t = 0; t < 12000 && io_oe !== 1'b1; t++) @(posedge hclk);
      note(32'(t < 600 * TK), 32'h1);
      note(outs, 32'h1B);
      rd(32'(sas_pkg::A_STAT), 32'h201);
      // lamp duty over one 500 ms span of a held alarm: one 10 ms flash
      lc = 0;
      repeat (500 * TK)
      begin
         @(posedge hclk);
         lc += int'(alarm_lamp_out);
      end
      note(32'(lc), 32'(10 * TK));
      press <= 1'b0;
      photo_code <= 5'h04;
      for (t = 0; t < 12000 && io_oe !== 1'b0; t++) @(posedge hclk);
      repeat (2) @(posedge hclk);
      note(outs, 32'h4);
      for (t = 0; t < 20000 && io_dump_en === 1'b1; t++) @(posedge hclk);
      note(32'(t > 1290 * TK && t < 1310 * TK), 32'h1);
      rd(32'(sas_pkg::A_STAT), 32'h4);
      remote <= 1'b1;
      for (t = 0; t < 8000 && horn_drive !== 1'b1; t++) @(posedge hclk);
      note(32'(t > 320 * TK && t < 350 * TK), 32'h1);
      note(outs, 32'h2);
      rd(32'(sas_pkg::A_STAT), 32'h6);
      note(32'({hresp, memory_lamp_out, alarm_lamp_out}), 32'h0);
      remote <= 1'b0;
      test_done();
   end
endmodule
